//--- rtl/pciu_pkg.sv
// Constants and types shared by the pin change interrupt unit
package pciu_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int unsigned CH_NUM   = 8;
	localparam int unsigned PORT_NUM = 4;
	localparam int unsigned ADDR_W   = 12;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_TRIG = 8'hE9;
	localparam logic [7:0] IDX_NEG  = 8'hEA;
	localparam logic [7:0] IDX_POS  = 8'hEB;
	localparam logic [7:0] IDX_FLAG = 8'hEC;
	localparam logic [7:0] IDX_STAT = 8'hF0;
	localparam logic [7:0] IDX_MASK = 8'hF1;
	localparam logic [7:0] IDX_SRC0 = 8'hF9; // Channels 0..6 at F9..FF
	localparam logic [7:0] IDX_SRC7 = 8'hF7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_TRIG = 8'h34;
	localparam logic [7:0] RST_NEG  = 8'h00;
	localparam logic [7:0] RST_POS  = 8'h00;
	localparam logic [7:0] RST_FLAG = 8'h00;
	localparam logic [7:0] RST_STAT = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [5:0] RST_SRC  = 6'h00;
	localparam logic [31:0] RST_PIN = 32'hFFFF_FFFF; // Pins idle high

	// ------------------------------------------------------------
	// Field layout of a source select register
	// ------------------------------------------------------------
	localparam int unsigned SRC_BIT_LSB  = 0;
	localparam int unsigned SRC_PORT_LSB = 4;
	localparam logic [2:0]  PORT_LAST    = 3'h3;

	// Trigger type encodings
	localparam logic TRIG_LEVEL = 1'b0;
	localparam logic TRIG_EDGE  = 1'b1;

	typedef struct packed {
		logic [2:0] port_sel;
		logic [2:0] bit_sel;
	} pciu_src_type;

endpackage

//--- rtl/pciu_top.sv
// Pin change interrupt unit: eight channel pin detector with APB registers
`timescale 1ns/1ps

module pciu_top
	import pciu_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Port pins, port n on bits 8n+7..8n
	input  wire logic [31:0]       port_pins_i,
	// Requests toward the processor
	output logic                   pin_irq_o,
	output logic                   wake_req_o
);

	// ------------------------------------------------------------
	// Address decoding helpers
	// ------------------------------------------------------------

	// Maps an index to a source select channel; bit 3 is the hit
	function automatic logic [3:0] src_chan(input logic [7:0] idx);
		logic [3:0] r;
		r = 4'h0;
		if (idx == IDX_SRC7) begin
			r = 4'hF;
		end else if (idx >= IDX_SRC0) begin
			r = {1'b1, 3'(idx - IDX_SRC0)};
		end
		return r;
	endfunction

	// Any index this block answers to
	function automatic logic idx_mapped(input logic [7:0] idx);
		logic       m;
		logic [3:0] s;
		m = 1'b0;
		s = src_chan(idx);
		case (idx)
			IDX_TRIG, IDX_NEG, IDX_POS, IDX_FLAG,
			IDX_STAT, IDX_MASK: begin
				m = 1'b1;
			end
			default: begin
				m = s[3];
			end
		endcase
		return m;
	endfunction

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic [7:0] bus_idx;
	logic       addr_ok;
	logic       setup_ph;
	logic       wr_acc;
	logic       wr_lane;
	logic [3:0] wr_src;
	logic [7:0] wdat;

	// Word aligned inside the low kilobyte only
	assign bus_idx  = paddr_i[9:2];
	assign addr_ok  = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0)
	                  && idx_mapped(bus_idx);
	assign setup_ph = psel_i && !penable_i;
	// Zero wait state: the access phase always completes
	assign wr_acc   = psel_i && penable_i && pwrite_i && addr_ok;
	assign wr_lane  = wr_acc && pstrb_i[0]; // Registers sit in lane 0
	// Source channel addressed by a write
	assign wr_src   = src_chan(bus_idx);
	assign wdat     = pwdata_i[7:0];

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [7:0]   trig_q;
	logic [7:0]   neg_q;
	logic [7:0]   pos_q;
	logic [7:0]   mask_q;
	pciu_src_type src_q [CH_NUM];

	// Trigger type, polarity enables and interrupt mask
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			trig_q <= RST_TRIG;
			neg_q  <= RST_NEG;
			pos_q  <= RST_POS;
			mask_q <= RST_MASK;
		end else if (wr_lane) begin
			case (bus_idx)
				IDX_TRIG: begin
					trig_q <= wdat;
				end
				IDX_NEG: begin
					neg_q  <= wdat;
				end
				IDX_POS: begin
					pos_q  <= wdat;
				end
				IDX_MASK: begin
					mask_q <= wdat;
				end
				default: begin
					mask_q <= mask_q;
				end
			endcase
		end
	end

	// Source select, one register per channel; reserved bits drop
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < CH_NUM; i++) begin
				src_q[i] <= RST_SRC;
			end
		end else if (wr_lane && wr_src[3]) begin
			src_q[wr_src[2:0]] <= {wdat[SRC_PORT_LSB+:3],
			                       wdat[SRC_BIT_LSB+:3]};
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [31:0] pin_meta_q;
	logic [31:0] pin_sync_q;

	// Pins are asynchronous to the bus clock
	// Reset to the idle high level, so release shows no false edge
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta_q <= RST_PIN;
			pin_sync_q <= RST_PIN;
		end else begin
			pin_meta_q <= port_pins_i;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Per channel selection and detection
	// ------------------------------------------------------------
	logic [7:0] ch_lvl;   // Selected synchronised level
	logic [7:0] ch_prev_q;
	logic [7:0] ch_rise;
	logic [7:0] ch_fall;
	logic [7:0] ch_edge;  // Enabled edge seen this cycle
	logic [7:0] ch_act;   // Enabled level condition present
	logic [7:0] ch_evt;   // Event toward status and wake

	// One detector per channel, fed from the synchronised pins
	for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
		// Reserved ports read as high: no low level, no edges
		always_comb begin
			if (src_q[c].port_sel > PORT_LAST) begin
				ch_lvl[c] = 1'b1;
			end else begin
				ch_lvl[c] = pin_sync_q[{src_q[c].port_sel[1:0],
				                        src_q[c].bit_sel}];
			end
		end

		// Edges compare this sample with the previous one
		assign ch_rise[c] = ch_lvl[c] && !ch_prev_q[c];
		assign ch_fall[c] = !ch_lvl[c] && ch_prev_q[c];
		assign ch_edge[c] = (pos_q[c] && ch_rise[c])
		                    || (neg_q[c] && ch_fall[c]);
		assign ch_act[c]  = (pos_q[c] && ch_lvl[c])
		                    || (neg_q[c] && !ch_lvl[c]);
		// Mode picks which of the two counts as an event
		assign ch_evt[c]  = (trig_q[c] == TRIG_EDGE) ? ch_edge[c]
		                                             : ch_act[c];
	end

	// Previous sample; starts high like a released key
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ch_prev_q <= 8'hFF;
		end else begin
			ch_prev_q <= ch_lvl;
		end
	end

	// ------------------------------------------------------------
	// Channel flags
	// ------------------------------------------------------------
	logic [7:0] flag_q;
	logic [7:0] flag_d;
	logic [7:0] flag_clr;

	// A written zero clears an edge channel flag
	assign flag_clr = (wr_lane && bus_idx == IDX_FLAG) ? ~wdat
	                                                   : 8'h00;

	// Level channels track the pin; edge channels latch events
	always_comb begin
		for (int i = 0; i < CH_NUM; i++) begin
			if (trig_q[i] == TRIG_LEVEL) begin
				flag_d[i] = !ch_lvl[i];
			end else begin
				// Set wins over a clear in the same cycle
				flag_d[i] = (flag_q[i] && !flag_clr[i])
				            || ch_edge[i];
			end
		end
	end

	// Flag register, cleared by reset on every channel
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_q <= RST_FLAG;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ------------------------------------------------------------
	// Sticky status, mask and request outputs
	// ------------------------------------------------------------
	logic [7:0] stat_q;
	logic [7:0] stat_clr;
	logic       irq_q;
	logic       wake_q;

	// Write one to clear; a new event in the same cycle survives
	assign stat_clr = (wr_lane && bus_idx == IDX_STAT) ? wdat : 8'h00;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stat_q <= RST_STAT;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | ch_evt;
		end
	end

	// One request line; software polls the flags for the source
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

	// Wake needs no clear: it asks while an unmasked event is seen
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= |(ch_evt & mask_q);
		end
	end

	// Registered requests keep decode glitches off the lines
	assign pin_irq_o  = irq_q;
	assign wake_req_o = wake_q;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [7:0]  rd_val;
	logic [3:0]  rd_src;
	logic [31:0] prdata_q;
	logic        slverr_q;

	// Source channel addressed by a read
	assign rd_src = src_chan(bus_idx);

	// Read value; source registers show reserved bits as zero
	always_comb begin
		case (bus_idx)
			IDX_TRIG: begin
				rd_val = trig_q;
			end
			IDX_NEG: begin
				rd_val = neg_q;
			end
			IDX_POS: begin
				rd_val = pos_q;
			end
			IDX_FLAG: begin
				rd_val = flag_q;
			end
			IDX_STAT: begin
				rd_val = stat_q;
			end
			IDX_MASK: begin
				rd_val = mask_q;
			end
			default: begin
				if (rd_src[3]) begin
					rd_val = {1'b0, src_q[rd_src[2:0]].port_sel,
					          1'b0, src_q[rd_src[2:0]].bit_sel};
				end else begin
					rd_val = 8'h00;
				end
			end
		endcase
	end

	// Captured in the setup cycle so the data leaves a flip-flop
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else if (setup_ph) begin
			prdata_q <= (!pwrite_i && addr_ok) ? {24'h00_0000, rd_val}
			                                   : 32'h0000_0000;
			slverr_q <= !addr_ok;
		end
	end

	// Every access phase is answered at once
	assign pready_o  = 1'b1;
	assign prdata_o  = prdata_q;
	assign pslverr_o = slverr_q && psel_i && penable_i;

endmodule

//--- dv/pciu_checker.sv
// Port level assertions for the pin change interrupt unit
`timescale 1ns/1ps

module pciu_checker
	import pciu_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	input  wire logic [31:0]       prdata_o,
	input  wire logic              pready_o,
	input  wire logic              pslverr_o,
	// Pins and requests
	input  wire logic [31:0]       port_pins_i,
	input  wire logic              pin_irq_o,
	input  wire logic              wake_req_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	property p_ready;
		psel_i && penable_i |-> pready_o;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_misal;
		psel_i && penable_i && paddr_i[1:0] != 2'h0 |-> pslverr_o;
	endproperty
	a_misal: assert property (p_misal) else $error("no error");
	property p_mapped;
		psel_i && penable_i && paddr_i inside {12'h3A4, 12'h3B0}
			|-> !pslverr_o;
	endproperty
	a_mapped: assert property (p_mapped) else $error("bad error");
	property p_errz;
		psel_i && penable_i && !pwrite_i && pslverr_o |-> prdata_o == 32'h0;
	endproperty
	a_errz: assert property (p_errz) else $error("error data");
	property p_upper;
		psel_i && penable_i && !pwrite_i |-> prdata_o[31:8] == 24'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper data");

	// ------------------------------------------------------------
	// Requests: status changes come from events or from writes
	// ------------------------------------------------------------
	property p_irq_up;
		$rose(pin_irq_o) |->
			$past(wake_req_o) || $past(psel_i && penable_i && pwrite_i, 2);
	endproperty
	a_irq_up: assert property (p_irq_up) else $error("irq rise");
	property p_irq_dn;
		$fell(pin_irq_o) |-> $past(psel_i && penable_i && pwrite_i, 2);
	endproperty
	a_irq_dn: assert property (p_irq_dn) else $error("irq fall");
	// Quiet pins and bus cannot produce a fresh event
	property p_quiet;
		(!psel_i && $stable(port_pins_i))[*5] |=> !$rose(wake_req_o);
	endproperty
	a_quiet: assert property (p_quiet) else $error("wake idle");
endmodule

bind pciu_top pciu_checker u_pciu_checker (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o),
	.port_pins_i(port_pins_i), .pin_irq_o(pin_irq_o),
	.wake_req_o(wake_req_o)
);

//--- dv/pciu_keypad.sv
// Keypad model: a held key pulls its port pin low
`timescale 1ns/1ps

module pciu_keypad (
	// Clock
	input  wire logic        ref_clk_i,
	// Keys held down, one per pin
	input  wire logic [31:0] press_i,
	// Pin levels, pulled up while idle
	output logic      [31:0] port_pins_o
);
	// Contacts settle on the clock, so a press lasts whole cycles
	initial port_pins_o = 32'hFFFFFFFF;
	always @(posedge ref_clk_i) begin
		port_pins_o <= ~press_i;
	end
endmodule

//--- dv/pciu_top_tb_top.sv
// Self-checking testbench for the pin change interrupt unit
`timescale 1ns/1ps

module pciu_top_tb_top;
	import pciu_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [3:0]  strb = 4'hF;
	logic [31:0] press = 32'h0;
	logic [31:0] rdat;
	logic        rerr;
	wire  [31:0] prdata;
	wire  [31:0] pins;
	wire         prdy;
	wire         perr;
	wire         irq;
	wire         wake;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	// ------------------------------------------------------------
	// Design, keypad, clock and hang guard
	// ------------------------------------------------------------
	pciu_top u_pciu_top (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.pstrb_i(strb), .prdata_o(prdata), .pready_o(prdy),
		.pslverr_o(perr), .port_pins_i(pins), .pin_irq_o(irq),
		.wake_req_o(wake));
	pciu_keypad u_pciu_keypad (.ref_clk_i(clk), .press_i(press),
		.port_pins_o(pins));
	always #4 clk = ~clk;
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			close_out;
		end
	end

	// ------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rdat = prdata;
		rerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task rc(input string n, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rdat & m);
	endtask
	// Pin changes need about four cycles to reach the flags
	task settle;
		repeat (6) @(negedge clk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		rc("trig", 12'h3A4, 32'hFFFFFFFF, 32'h34);
		rc("neg", 12'h3A8, 32'hFFFFFFFF, 32'h0);
		rc("pos", 12'h3AC, 32'hFFFFFFFF, 32'h0);
		rc("flags", 12'h3B0, 32'hFFFFFFFF, 32'h0);
		rc("src7", 12'h3DC, 32'hFFFFFFFF, 32'h0);
		wr(12'h3DC, 32'hFF);
		rc("src7 wr", 12'h3DC, 32'hFFFFFFFF, 32'h77);
		apb(1'b0, 12'h3B4, 32'h0);
		chk("unmap", 32'h1, {31'h0, rerr});
		wr(12'h3A5, 32'hFF);
		chk("misal", 32'h1, {31'h0, rerr});
		apb(1'b0, 12'h7A4, 32'h0);
		chk("high addr", 32'h1, {31'h0, rerr});
	endtask
	task t_level;
		wr(12'h3E8, 32'h13);
		press[11] <= 1'b1;
		settle;
		rc("lvl lo", 12'h3B0, 32'h2, 32'h2);
		wr(12'h3B0, 32'h0);
		rc("ro clr", 12'h3B0, 32'h2, 32'h2);
		press[11] <= 1'b0;
		settle;
		rc("lvl hi", 12'h3B0, 32'h2, 32'h0);
		wr(12'h3B0, 32'hFF);
		rc("ro set", 12'h3B0, 32'h2, 32'h0);
		wr(12'h3C0, 32'hFF);
		wr(12'h3A8, 32'h2);
		wr(12'h3C4, 32'h2);
		press[11] <= 1'b1;
		settle;
		chk("lvl irq", 32'h1, {31'h0, irq});
		rc("stat", 12'h3C0, 32'h2, 32'h2);
		wr(12'h3C4, 32'h0);
		settle;
		chk("masked", 32'h0, {31'h0, irq});
		press[11] <= 1'b0;
		settle;
		wr(12'h3C0, 32'hFF);
		wr(12'h3E8, 32'h43);
		press[11] <= 1'b1;
		settle;
		rc("resv", 12'h3B0, 32'h2, 32'h0);
		press[11] <= 1'b0;
	endtask
	task t_edge;
		int i;
		wr(12'h3EC, 32'h25);
		wr(12'h3AC, 32'h4);
		wr(12'h3C4, 32'h4);
		settle;
		wr(12'h3B0, 32'h0);
		wr(12'h3C0, 32'hFF);
		rc("idle", 12'h3B0, 32'h4, 32'h0);
		press[21] <= 1'b1;
		settle;
		rc("no fall", 12'h3B0, 32'h4, 32'h0);
		press[21] <= 1'b0;
		for (i = 0; i < 8 && wake !== 1'b1; i++) @(negedge clk);
		chk("wake", 32'h1, {31'h0, wake});
		settle;
		chk("irq", 32'h1, {31'h0, irq});
		rc("rise", 12'h3B0, 32'h4, 32'h4);
		strb <= 4'h0;
		wr(12'h3B0, 32'h0);
		strb <= 4'hF;
		rc("strb", 12'h3B0, 32'h4, 32'h4);
		wr(12'h3B0, 32'h0);
		rc("clear", 12'h3B0, 32'h4, 32'h0);
		wr(12'h3C0, 32'h4);
		settle;
		chk("irq off", 32'h0, {31'h0, irq});
		wr(12'h3A8, 32'h4);
		press[21] <= 1'b1;
		settle;
		rc("fall", 12'h3B0, 32'h4, 32'h4);
		wr(12'h3B0, 32'h0);
		settle;
		rc("once", 12'h3B0, 32'h4, 32'h0);
		wr(12'h3A4, 32'h30);
		settle;
		rc("to lvl", 12'h3B0, 32'h4, 32'h4);
	endtask

	// Verdict and end of run
	task close_out;
		$display("Compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_level;
		t_edge;
		close_out;
	end
endmodule
